// ### rtl/timer_defines.svh
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// Register byte addresses
`define ADDR_MODE_CTRL     8'ha0
`define ADDR_COUNT_LOW     8'ha1
`define ADDR_COUNT_HIGH    8'ha2
`define ADDR_EDGE_CTRL     8'hbf
`define ADDR_IRQ_STATUS    8'hc0
`define ADDR_IRQ_CLEAR     8'hc1
`define ADDR_IRQ_MASK      8'hc2
`define ADDR_CONVERTER     8'hc3

// Mode register field positions
`define MODE_BIT_ENABLE    7
`define MODE_RATE_MSB      6
`define MODE_RATE_LSB      4
`define MODE_BIT_SOURCE    3
`define MODE_BIT_IRQ_EN    1
`define MODE_BIT_IRQ_FLAG  0

// Edge and width control field positions
`define EDGE_BIT_PIN_HI    4
`define EDGE_BIT_PIN_LO    3
`define EDGE_BIT_WIDTH_EN  1
`define EDGE_BIT_DIRECTION 0

// Interrupt status bit positions
`define IRQ_BIT_OVERFLOW   0
`define IRQ_BIT_PULSE_DONE 1
`define IRQ_BIT_EDGE_SEEN  2
`define IRQ_STATUS_BITS    3

// Reset values
`define MODE_RESET         8'h00
`define EDGE_RESET         8'h10
`define COUNT_RESET        16'h0000
`define BYTE_RESET         8'h00

// Prescaler: divide by 256 at code 0, halving per step
`define PRESCALE_WIDTH     8
`define PRESCALE_FULL_MASK 8'hff

`endif

// ### rtl/timer_pkg.sv
package timer_pkg;

  // Mode register layout
  typedef struct packed {
    logic       countEnable;
    logic [2:0] prescaleSelect;
    logic       countSourceSelect;
    logic       unused;
    logic       irqEnable;
    logic       irqFlag;
  } mode_reg_t;

  // Edge and width control layout
  typedef struct packed {
    logic [2:0] unusedHigh;
    logic       port0Pin0EdgeHi;
    logic       port0Pin0EdgeLo;
    logic       unusedMid;
    logic       pulseWidthEnable;
    logic       edgeDirection;
  } edge_ctrl_t;

  // Pulse width measurement states
  typedef enum logic [1:0] {
    PW_ARM  = 2'b00,
    PW_RUN  = 2'b01,
    PW_DONE = 2'b10
  } pulse_state_t;

endpackage

// ### rtl/edge_sync_detect.sv
`timescale 1ns/1ps
`default_nettype none
module edge_sync_detect #(
  parameter int WIDTH  = 2,
  parameter int STAGES = 2
) (
  input  wire logic             clk_sys,  // System clock
  input  wire logic             resetn,   // Async reset, active low
  input  wire logic [WIDTH-1:0] sigIn,    // Asynchronous inputs
  output logic      [WIDTH-1:0] sigRise,  // One-cycle rising edge pulse
  output logic      [WIDTH-1:0] sigFall   // One-cycle falling edge pulse
);

  // Refuse a chain too short to settle metastability
  if (STAGES < 2) begin : g_bad_stages
    $error("edge_sync_detect needs at least two stages");
  end

  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    logic [STAGES-1:0] syncChain;
    logic              prevLevel;

    // Synchroniser chain; first flop feeds only the second
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        syncChain <= '0;
        prevLevel <= 1'b0;
      end else begin
        syncChain <= {syncChain[STAGES-2:0], sigIn[i]};
        prevLevel <= syncChain[STAGES-1];
      end
    end

    // One pulse per settled edge
    assign sigRise[i] = syncChain[STAGES-1] & ~prevLevel;
    assign sigFall[i] = ~syncChain[STAGES-1] & prevLevel;
  end

endmodule
`default_nettype wire

// ### rtl/sixteen_bit_timer_event_counter.sv
// Notes on behaviour
// RULE1 - Count up over 16 bits; wrap FFFF to 0000 keeps counting, sets flag.
// RULE2 - Counter advances only while mode bit 7 enable is one.
// RULE3 - Rate field bits 6:4 divides CPU clock, 256 at 000 to 2 at 111.
// RULE4 - Source bit 3 zero: CPU clock; one: pin or oscillator by converter enable.
// RULE5 - Interrupt reaches the processor only while mode bit 1 is one; here an unmasked status bit also drives irq whatever bit 1 holds.
// RULE6 - Mode bit 0 reads one while an interrupt request is pending.
// RULE7 - Event mode counts falling edges at direction zero, rising at one.
// RULE8 - Edge register bit 1 enables width measuring; direction picks high or low.
// RULE9 - Software keeps source bit zero while width measuring is enabled.
// RULE10 - High pulse: rise starts, fall stops; low pulse: fall starts, rise stops.
// RULE11 - Pulse end stops counter, holds value, sets flag; clearing flag rearms.
// RULE12 - Overflow comes after 65536 minus preset input clocks.
// RULE13 - Reading high byte returns it and copies low byte into its latch.
// RULE14 - Software reads high byte before low byte for a coherent value.
// RULE15 - Writing high byte loads it with latched low byte into the counter.
// RULE16 - Software writes low byte before high byte when presetting.
// RULE17 - Writing low byte alone updates only the latch, not the counter.
// RULE18 - Pin and oscillator are synchronised; each edge gives one count pulse.
// RULE19 - Hardware only sets the flag; a same-cycle set wins over a clear.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module sixteen_bit_timer_event_counter #(
  parameter int COUNT_WIDTH = 16,
  parameter int SYNC_STAGES = 2
) (
  input  wire logic       clk_sys,             // System clock, 100 MHz
  input  wire logic       resetn,              // Async reset, active low
  input  wire logic [7:0] busAddr,             // Register address
  input  wire logic [7:0] busWdata,            // Write data
  input  wire logic       busWrite,            // Write strobe
  input  wire logic       busRead,             // Read strobe
  output logic      [7:0] busRdata,            // Read data, cycle after strobe
  input  wire logic       externalCountInput,  // External event pin
  input  wire logic       resistanceOscillator,// Converter oscillator output
  output logic            irq                  // Level interrupt output
);

  // The byte-pair access scheme only serves a 16-bit counter
  if (COUNT_WIDTH != 16) begin : g_bad_width
    $error("counter width must be 16 for the byte-pair interface");
  end

  localparam int PW = `PRESCALE_WIDTH;
  localparam int SB = `IRQ_STATUS_BITS;
  localparam logic [7:0] MODE_INIT = `MODE_RESET;

  // Register state
  timer_pkg::mode_reg_t    modeReg;
  logic                    countEnableReg;
  logic [2:0]              prescaleSelectReg;
  logic                    countSourceReg;
  logic                    irqEnableReg;
  logic                    irqFlagReg;
  timer_pkg::edge_ctrl_t   edgeReg;
  timer_pkg::pulse_state_t pulseState;
  timer_pkg::pulse_state_t pulseNext;
  logic [15:0]             counterReg;
  logic [7:0]              lowLatchReg;
  logic                    converterEnableReg;
  logic [SB-1:0]           statusReg;
  logic [SB-1:0]           statusMaskReg;
  logic [PW-1:0]           divCountReg;
  logic [7:0]              readDataReg;

  // Decoded accesses
  logic wrMode;
  logic wrLow;
  logic wrHigh;
  logic wrEdge;
  logic wrStatusClear;
  logic wrMask;
  logic wrConverter;
  logic rdHigh;

  // Datapath terms
  logic [PW-1:0] rateMask;
  logic          prescaleTick;
  logic [1:0]    edgeRise;
  logic [1:0]    edgeFall;
  logic          measRise;
  logic          measFall;
  logic          eventEdge;
  logic          pulseMode;
  logic          startEdge;
  logic          stopEdge;
  logic          countTick;
  logic          overflowEvent;
  logic          pulseDoneEvent;
  logic          edgeCountEvent;
  logic [SB-1:0] statusSet;

  // Address decode of the strobes
  assign wrMode        = busWrite && (busAddr == `ADDR_MODE_CTRL);
  assign wrLow         = busWrite && (busAddr == `ADDR_COUNT_LOW);
  assign wrHigh        = busWrite && (busAddr == `ADDR_COUNT_HIGH);
  assign wrEdge        = busWrite && (busAddr == `ADDR_EDGE_CTRL);
  assign wrStatusClear = busWrite && (busAddr == `ADDR_IRQ_CLEAR);
  assign wrMask        = busWrite && (busAddr == `ADDR_IRQ_MASK);
  assign wrConverter   = busWrite && (busAddr == `ADDR_CONVERTER);
  assign rdHigh        = busRead && (busAddr == `ADDR_COUNT_HIGH);

  // Pin and oscillator synchronised; bit 0 pin, bit 1 oscillator
  // Edges reach the counter three cycles after a pin moves
  edge_sync_detect #(
    .WIDTH  (2),
    .STAGES (SYNC_STAGES)
  ) u_edges (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .sigIn   ({resistanceOscillator, externalCountInput}),
    .sigRise (edgeRise),
    .sigFall (edgeFall)
  ); // [RULE18]

  // Measured input picked by the converter enable
  assign measRise = converterEnableReg ? edgeRise[1] : edgeRise[0]; // [RULE4]
  assign measFall = converterEnableReg ? edgeFall[1] : edgeFall[0]; // [RULE4]

  // Event edge by direction: zero falling, one rising
  assign eventEdge = edgeReg.edgeDirection ? measRise : measFall; // [RULE7]
  assign pulseMode = edgeReg.pulseWidthEnable; // [RULE8]

  // Start and stop edges of the measured pulse
  always_comb begin
    if (edgeReg.edgeDirection) begin
      startEdge = measFall; // [RULE10]
      stopEdge  = measRise; // [RULE10]
    end else begin
      startEdge = measRise; // [RULE10]
      stopEdge  = measFall; // [RULE10]
    end
  end

  // Prescale mask: all ones at code 000, one bit at code 111
  assign rateMask     = `PRESCALE_FULL_MASK >> modeReg.prescaleSelect; // [RULE3]
  assign prescaleTick = (divCountReg & rateMask) == rateMask; // [RULE3]

  // Prescale divider runs only while counting is enabled
  // Restarting at enable makes the first tick a full period after it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      divCountReg <= '0;
    end else if (!modeReg.countEnable) begin
      divCountReg <= '0;
    end else begin
      divCountReg <= divCountReg + 1'b1;
    end
  end

  // Count enable pulse from the selected source
  always_comb begin
    countTick      = 1'b0;
    edgeCountEvent = 1'b0;
    if (modeReg.countEnable) begin // [RULE2]
      if (pulseMode) begin
        countTick = (pulseState == timer_pkg::PW_RUN) && prescaleTick; // [RULE8]
      end else if (!modeReg.countSourceSelect) begin
        countTick = prescaleTick; // [RULE4]
      end else begin
        countTick      = eventEdge; // [RULE7]
        edgeCountEvent = countTick;
      end
    end
  end

  // Wrap from all ones to zero
  // Counting carries on past the wrap; the flag and the overflow status bit record it
  assign overflowEvent = countTick && (counterReg == 16'hffff); // [RULE1]

  // Pulse measurement sequencing
  // A start edge is refused while the flag still holds the last result
  always_comb begin
    pulseNext      = pulseState;
    pulseDoneEvent = 1'b0;
    if (!pulseMode || !modeReg.countEnable) begin
      pulseNext = timer_pkg::PW_ARM;
    end else begin
      unique case (pulseState)
        timer_pkg::PW_ARM: begin
          if (!modeReg.irqFlag && startEdge) begin
            pulseNext = timer_pkg::PW_RUN; // [RULE10]
          end
        end
        timer_pkg::PW_RUN: begin
          if (stopEdge) begin
            pulseNext      = timer_pkg::PW_DONE; // [RULE11]
            pulseDoneEvent = 1'b1; // [RULE11]
          end
        end
        timer_pkg::PW_DONE: begin
          if (!modeReg.irqFlag) begin
            pulseNext = timer_pkg::PW_ARM; // [RULE11]
          end
        end
        default: begin
          pulseNext = timer_pkg::PW_ARM;
        end
      endcase
    end
  end

  // Pulse state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pulseState <= timer_pkg::PW_ARM;
    end else begin
      pulseState <= pulseNext;
    end
  end

  // Sixteen-bit counter: software load first, else count
  // A high-byte write wins over a same-cycle tick so a preset is never lost
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      counterReg <= `COUNT_RESET;
    end else if (wrHigh) begin
      counterReg <= {busWdata, lowLatchReg}; // [RULE15] [RULE12]
    end else if (countTick) begin
      counterReg <= counterReg + 16'h0001; // [RULE1] [RULE12]
    end
  end

  // Low byte holding latch
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lowLatchReg <= `BYTE_RESET;
    end else if (wrLow) begin
      lowLatchReg <= busWdata; // [RULE17]
    end else if (rdHigh) begin
      lowLatchReg <= counterReg[7:0]; // [RULE13]
    end
  end

  // Mode register fields other than the request flag
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      countEnableReg    <= MODE_INIT[`MODE_BIT_ENABLE];
      prescaleSelectReg <= MODE_INIT[`MODE_RATE_MSB:`MODE_RATE_LSB];
      countSourceReg    <= MODE_INIT[`MODE_BIT_SOURCE];
      irqEnableReg      <= MODE_INIT[`MODE_BIT_IRQ_EN];
    end else if (wrMode) begin
      countEnableReg    <= busWdata[`MODE_BIT_ENABLE]; // [RULE2]
      prescaleSelectReg <= busWdata[`MODE_RATE_MSB:`MODE_RATE_LSB]; // [RULE3]
      countSourceReg    <= busWdata[`MODE_BIT_SOURCE]; // [RULE4]
      irqEnableReg      <= busWdata[`MODE_BIT_IRQ_EN]; // [RULE5]
    end
  end

  // Mode view as software reads it; bit 2 has no storage and reads zero.
  // Each field keeps its own flop so that only one process drives it.
  assign modeReg = {countEnableReg, prescaleSelectReg, countSourceReg, 1'b0,
                    irqEnableReg, irqFlagReg}; // [RULE6]

  // Request flag: hardware sets, software writes, set wins
  // Writing a one raises the flag by hand, as software may wish
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irqFlagReg <= MODE_INIT[`MODE_BIT_IRQ_FLAG];
    end else if (overflowEvent || pulseDoneEvent) begin
      irqFlagReg <= 1'b1; // [RULE19] [RULE1] [RULE11]
    end else if (wrMode) begin
      irqFlagReg <= busWdata[`MODE_BIT_IRQ_FLAG]; // [RULE19]
    end
  end

  // Edge and width control register
  // Pin edge bits are stored for software only and steer nothing here
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      edgeReg <= `EDGE_RESET;
    end else if (wrEdge) begin
      edgeReg.unusedHigh       <= 3'h0;
      edgeReg.port0Pin0EdgeHi  <= busWdata[`EDGE_BIT_PIN_HI];
      edgeReg.port0Pin0EdgeLo  <= busWdata[`EDGE_BIT_PIN_LO];
      edgeReg.unusedMid        <= 1'b0;
      edgeReg.pulseWidthEnable <= busWdata[`EDGE_BIT_WIDTH_EN]; // [RULE8]
      edgeReg.edgeDirection    <= busWdata[`EDGE_BIT_DIRECTION]; // [RULE7]
    end
  end

  // Converter enable selects the oscillator as external source
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      converterEnableReg <= 1'b0;
    end else if (wrConverter) begin
      converterEnableReg <= busWdata[0];
    end
  end

  // Sticky status events
  always_comb begin
    statusSet                      = '0;
    statusSet[`IRQ_BIT_OVERFLOW]   = overflowEvent;
    statusSet[`IRQ_BIT_PULSE_DONE] = pulseDoneEvent;
    statusSet[`IRQ_BIT_EDGE_SEEN]  = edgeCountEvent;
  end

  // Status bits: clear by writing ones, a new event wins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      statusReg <= '0;
    end else begin
      statusReg <= (statusReg & ~({SB{wrStatusClear}} & busWdata[SB-1:0])) | statusSet;
    end
  end

  // Status enable mask
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      statusMaskReg <= '0;
    end else if (wrMask) begin
      statusMaskReg <= busWdata[SB-1:0];
    end
  end

  // Interrupt line: gated request flag or enabled status bit
  assign irq = (modeReg.irqFlag && modeReg.irqEnable) // [RULE5]
             || |(statusReg & statusMaskReg);

  // Read data stands only in the cycle after the strobe
  // Idle cycles return zero so a stale byte is never taken for data
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      readDataReg <= `BYTE_RESET;
    end else if (!busRead) begin
      readDataReg <= `BYTE_RESET;
    end else begin
      unique case (busAddr)
        `ADDR_MODE_CTRL:  readDataReg <= modeReg; // [RULE6]
        `ADDR_COUNT_LOW:  readDataReg <= lowLatchReg;
        `ADDR_COUNT_HIGH: readDataReg <= counterReg[15:8]; // [RULE13]
        `ADDR_EDGE_CTRL:  readDataReg <= edgeReg;
        `ADDR_IRQ_STATUS: readDataReg <= {{(8-SB){1'b0}}, statusReg};
        `ADDR_IRQ_MASK:   readDataReg <= {{(8-SB){1'b0}}, statusMaskReg};
        `ADDR_CONVERTER:  readDataReg <= {7'h00, converterEnableReg};
        default:          readDataReg <= `BYTE_RESET;
      endcase
    end
  end

  assign busRdata = readDataReg;

endmodule
`default_nettype wire

// ### testbench/timer_event_props.sv
`timescale 1ns/1ps
`default_nettype none
module timer_event_props (
  input wire logic       clk_sys,              // Clock
  input wire logic       resetn,               // Reset, active low
  input wire logic [7:0] busAddr,              // Address
  input wire logic [7:0] busWdata,             // Write data
  input wire logic       busWrite,             // Write strobe
  input wire logic       busRead,              // Read strobe
  input wire logic [7:0] busRdata,             // Read data
  input wire logic       externalCountInput,   // Event pin
  input wire logic       resistanceOscillator, // Oscillator
  input wire logic       irq                   // Interrupt
);
  logic [7:0] mode_reg;
  logic [7:0] edge_reg;
  logic [2:0] mask_reg;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Software view of the control registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= 8'h00;
      edge_reg <= 8'h10;
      mask_reg <= 3'h0;
    end else if (busWrite) begin
      if (busAddr == 8'ha0) mode_reg <= busWdata;
      if (busAddr == 8'hbf) edge_reg <= busWdata;
      if (busAddr == 8'hc2) mask_reg <= busWdata[2:0];
    end
  end
  chk_rdata_idle_zero : assert property (
    !busRead |=> busRdata == 8'h00) else $error("read data not zero");
  chk_unmapped_reads_zero : assert property (
    busRead && !(busAddr inside {8'ha0, 8'ha1, 8'ha2, 8'hbf, 8'hc0, 8'hc1, 8'hc2, 8'hc3})
    |=> busRdata == 8'h00) else $error("unmapped read not zero");
  chk_clear_reads_zero : assert property (
    busRead && busAddr == 8'hc1 |=> busRdata == 8'h00) else $error("clear reg read");
  chk_mode_readback : assert property (
    busRead && busAddr == 8'ha0 |=> (busRdata & 8'hfa) == (mode_reg & 8'hfa))
    else $error("mode readback wrong");
  chk_edge_readback : assert property (
    busRead && busAddr == 8'hbf |=> (busRdata & 8'h1b) == (edge_reg & 8'h1b))
    else $error("edge readback wrong");
  chk_irq_needs_enable : assert property (
    irq && mask_reg == 3'h0 |-> mode_reg[1]) else $error("irq without enable");
  chk_flag_drives_irq : assert property (
    busRead && busAddr == 8'ha0 && mode_reg[1] && mask_reg == 3'h0
    |=> busRdata[0] == $past(irq)) else $error("flag and irq differ");
  chk_low_latch_only : assert property (
    busWrite && busAddr == 8'ha1 ##1 !busWrite && !busRead ##1 busRead && busAddr == 8'ha1
    |=> busRdata == $past(busWdata, 3)) else $error("low latch wrong");
  chk_high_byte_load : assert property (
    busWrite && busAddr == 8'ha2 && !mode_reg[7] ##1 !busWrite && !busRead
    ##1 busRead && busAddr == 8'ha2 |=> busRdata == $past(busWdata, 3))
    else $error("high byte not loaded");
endmodule
bind sixteen_bit_timer_event_counter timer_event_props u_props (
  .clk_sys(clk_sys), .resetn(resetn), .busAddr(busAddr), .busWdata(busWdata),
  .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata),
  .externalCountInput(externalCountInput), .resistanceOscillator(resistanceOscillator),
  .irq(irq));
`default_nettype wire

// ### testbench/event_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module event_source_model (
  input  wire logic clk_sys,  // Clock
  output logic      pinLevel, // Event pin level
  output logic      oscLevel  // Oscillator level
);
  // Both lines start low
  initial begin
    pinLevel = 1'b0;
    oscLevel = 1'b0;
  end
  // Hold one line at a level for len cycles so no edge is lost
  task automatic drive(input logic sel, input logic lvl, input int len);
    @(posedge clk_sys);
    if (sel) oscLevel <= lvl;
    else pinLevel <= lvl;
    repeat (len - 1) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ### testbench/sixteen_bit_timer_event_counter_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_timer_event_counter_bench;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] busAddr = 8'h00;
  logic [7:0] busWdata = 8'h00;
  logic       busWrite = 1'b0;
  logic       busRead = 1'b0;
  logic [7:0] busRdata;
  logic       pin;
  logic       osc;
  logic       irq;
  logic [7:0] expQ[$];
  logic       rdPend = 1'b0;
  logic [7:0] lo, hi, v;
  int         mismatches = 0;
  int         check_count = 0;
  int         n;
  integer     seed = 32'h2e237da7;
  always #5 clk_sys = ~clk_sys;
  sixteen_bit_timer_event_counter u_dut (.clk_sys(clk_sys), .resetn(resetn),
    .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead),
    .busRdata(busRdata), .externalCountInput(pin), .resistanceOscillator(osc), .irq(irq));
  event_source_model u_src (.clk_sys(clk_sys), .pinLevel(pin), .oscLevel(osc));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busAddr <= a;
    busWdata <= d;
    busWrite <= 1'b1;
    @(posedge clk_sys);
    busWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    busAddr <= a;
    busRead <= 1'b1;
    expQ.push_back(e);
    @(posedge clk_sys);
    busRead <= 1'b0;
  endtask
  task automatic rdv(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge clk_sys);
    busRead <= 1'b0;
    @(posedge clk_sys);
    d = busRdata;
  endtask
  task automatic waitIrq(output int c);
    c = 0;
    while (irq !== 1'b1 && c < 2000) begin
      @(posedge clk_sys);
      c++;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Read data stands one cycle after the strobe; compare with the oldest note
  always @(posedge clk_sys) begin
    if (rdPend && expQ.size() > 0) check("read data", busRdata, expQ.pop_front());
    rdPend <= busRead;
  end
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'ha0, 8'h00);
    rd(8'hbf, 8'h10);
    rd(8'ha2, 8'h00);
    rd(8'ha1, 8'h00);
    rd(8'h55, 8'h00);
    rd(8'hc1, 8'h00);
    $display("test reset done");
    lo = 8'($random(seed));
    hi = 8'($random(seed));
    wr(8'ha1, lo);
    rd(8'ha1, lo);
    wr(8'ha2, hi);
    rd(8'ha2, hi);
    rd(8'ha1, lo);
    wr(8'ha1, 8'h00);
    rd(8'ha2, hi);
    rd(8'ha1, lo);
    $display("test byte pair done");
    for (int r = 0; r < 8; r++) begin
      wr(8'ha0, 8'h00);
      wr(8'ha1, 8'hfe);
      wr(8'ha2, 8'hff);
      wr(8'ha0, {1'b1, 3'(r), 4'h2});
      waitIrq(n);
      check("interval", 8'(n >= (512 >> r) - 2 && n <= (512 >> r) + 4), 8'h01);
      rd(8'ha0, {1'b1, 3'(r), 4'h3});
    end
    $display("test prescale done");
    wr(8'ha0, 8'h00);
    wr(8'hc1, 8'h07);
    wr(8'ha1, 8'hff);
    wr(8'ha2, 8'hff);
    wr(8'ha0, 8'hf0);
    repeat (20) @(posedge clk_sys);
    check("irq", {7'h0, irq}, 8'h00);
    rd(8'ha0, 8'hf1);
    rd(8'hc0, 8'h01);
    wr(8'hc2, 8'h01);
    @(posedge clk_sys);
    check("irq", {7'h0, irq}, 8'h01);
    wr(8'hc1, 8'h01);
    @(posedge clk_sys);
    check("irq", {7'h0, irq}, 8'h00);
    wr(8'hc2, 8'h00);
    wr(8'ha0, 8'h00);
    $display("test interrupt done");
    for (int p = 0; p < 2; p++) begin
      wr(8'hc3, 8'(p));
      wr(8'hbf, 8'h10 | 8'(p));
      wr(8'ha1, 8'h00);
      wr(8'ha2, 8'h00);
      wr(8'ha0, 8'h88);
      n = ($random(seed) & 7) + 1;
      repeat (n) begin
        u_src.drive(p[0], 1'b1, 4);
        u_src.drive(p[0], 1'b0, 4);
        u_src.drive(!p[0], 1'b1, 4);
        u_src.drive(!p[0], 1'b0, 4);
      end
      repeat (8) @(posedge clk_sys);
      rd(8'ha2, 8'h00);
      rd(8'ha1, 8'(n));
      wr(8'ha0, 8'h00);
    end
    rd(8'hc0, 8'h04);
    $display("test events done");
    for (int d = 0; d < 2; d++) begin
      wr(8'hc3, 8'h00);
      wr(8'hbf, 8'h12 | 8'(d));
      wr(8'ha1, 8'h00);
      wr(8'ha2, 8'h00);
      wr(8'ha0, 8'hf2);
      u_src.drive(1'b0, d[0], 10);
      u_src.drive(1'b0, !d[0], 40);
      u_src.drive(1'b0, d[0], 10);
      waitIrq(n);
      check("irq", {7'h0, irq}, 8'h01);
      repeat (40) @(posedge clk_sys);
      rd(8'ha2, 8'h00);
      rdv(8'ha1, v);
      check("width", 8'(v >= 8'd18 && v <= 8'd22), 8'h01);
      wr(8'ha0, 8'h00);
    end
    rd(8'hc0, 8'h06);
    $display("test pulse width done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
